//--- design/csc_pkg.sv
package csc_pkg;

  // Register map (printed offset is not a multiple of four: index, byte address = 4 x index)
  localparam logic [7:0] CSC_CCS_INDEX = 8'hEF;
  localparam logic [9:0] CSC_CCS_ADDR = {CSC_CCS_INDEX, 2'b00};
  localparam logic [7:0] CSC_CIF_INDEX = 8'hE0;
  localparam logic [9:0] CSC_CIF_ADDR = {CSC_CIF_INDEX, 2'b00};

  // converter_control_status fields
  localparam int CSC_ON_BIT = 7;
  localparam int CSC_RDY_BIT = 6;
  localparam int CSC_LOAD_BIT = 5;
  localparam logic [7:0] CSC_CCS_RESET = 8'h00;

  // card interface register fields
  localparam int CSC_VSEL_LSB = 0;
  localparam int CSC_REQ_BIT = 2;
  localparam int CSC_PRES_BIT = 3;
  localparam int CSC_ABORT_BIT = 4;
  localparam logic [1:0] CSC_VSEL_RESET = 2'h0;

  // Voltage codes
  localparam logic [1:0] CSC_V_OFF = 2'h0;
  localparam logic [1:0] CSC_V_1V8 = 2'h1;
  localparam logic [1:0] CSC_V_3V = 2'h2;
  localparam logic [1:0] CSC_V_5V = 2'h3;

  // Timing: clock rate in MHz; start, settle and off times in ns
  localparam int CSC_CLK_MHZ = 200;
  localparam int CSC_START_NS = 20000;
  localparam int CSC_SETTLE_1V8_NS = 20000;
  localparam int CSC_SETTLE_3V_NS = 30000;
  localparam int CSC_SETTLE_5V_NS = 40000;
  localparam int CSC_OFF_NS = 20000;
  localparam int CSC_START_CYC = (CSC_START_NS * CSC_CLK_MHZ + 999) / 1000;
  localparam int CSC_SETTLE_1V8_CYC = (CSC_SETTLE_1V8_NS * CSC_CLK_MHZ + 999) / 1000;
  localparam int CSC_SETTLE_3V_CYC = (CSC_SETTLE_3V_NS * CSC_CLK_MHZ + 999) / 1000;
  localparam int CSC_SETTLE_5V_CYC = (CSC_SETTLE_5V_NS * CSC_CLK_MHZ + 999) / 1000;
  localparam int CSC_OFF_CYC = (CSC_OFF_NS * CSC_CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    CSC_ST_OFF = 3'b000,
    CSC_ST_START = 3'b001,
    CSC_ST_READY = 3'b010,
    CSC_ST_RAMP = 3'b011,
    CSC_ST_LOADED = 3'b100,
    CSC_ST_DEACT = 3'b101
  } csc_state_t;

  // Analog stage controls
  typedef struct packed {
    logic enable;
    logic [1:0] level;
    logic supply;
  } csc_drive_t;

  // Register bus request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [9:0] addr;
    logic [31:0] wdata;
  } csc_req_t;

endpackage : csc_pkg

//--- design/csc_timer.sv
`timescale 1ns/1ps
module csc_timer
  import csc_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Control
  input wire logic load,
  input wire logic [WIDTH-1:0] count,
  output logic done
);

  logic [WIDTH-1:0] cnt_reg;
  logic run_reg;

  // A reload restarts the wait, so a new request never inherits a half-spent delay
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
    end else if (load) begin
      cnt_reg <= count;
      run_reg <= 1'b1;
    end else if (run_reg) begin
      if (cnt_reg <= WIDTH'(1)) begin
        run_reg <= 1'b0;
      end
      cnt_reg <= cnt_reg - WIDTH'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else begin
      done <= run_reg && !load && (cnt_reg <= WIDTH'(1));
    end
  end

endmodule : csc_timer

//--- design/csc_avalon_slave.sv
`timescale 1ns/1ps
module csc_avalon_slave
  import csc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Avalon-MM
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic avs_waitrequest,
  // Core side: one-cycle strobe of the taken request
  output csc_req_t req
);

  logic busy_reg;

  // One wait state: the request is taken on the second edge, then released
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= (avs_read || avs_write) && !busy_reg;
    end
  end

  always_comb begin
    avs_waitrequest = !busy_reg;
    req.rd = avs_read && busy_reg;
    req.wr = avs_write && busy_reg;
    req.addr = avs_address;
    req.wdata = avs_writedata;
  end

endmodule : csc_avalon_slave

//--- design/csc_card_supply_ctrl.sv
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
module csc_card_supply_ctrl
  import csc_pkg::*;
#(
  parameter int START_CYC = CSC_START_CYC,
  parameter int SETTLE_1V8_CYC = CSC_SETTLE_1V8_CYC,
  parameter int SETTLE_3V_CYC = CSC_SETTLE_3V_CYC,
  parameter int SETTLE_5V_CYC = CSC_SETTLE_5V_CYC,
  parameter int OFF_CYC = CSC_OFF_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Card side
  input wire logic card_presence_input,
  output logic converter_enable,
  output logic [1:0] converter_level,
  output logic card_supply_output
);

  localparam int TW = 16;

  csc_req_t req;
  csc_state_t state_reg;
  csc_state_t state_next;
  logic converter_on_reg;
  logic card_supply_request_reg;
  logic [1:0] card_voltage_select_reg;
  logic [1:0] applied_level_reg;
  logic lockout_reg;
  logic abort_seen_reg;
  logic [31:0] rdata_reg;
  logic wait_reg;
  csc_drive_t drive_reg;
  logic tmr_load;
  logic [TW-1:0] tmr_count;
  logic tmr_done;
  logic wr_ccs;
  logic wr_cif;
  logic pres_lost;

  function automatic logic [TW-1:0] settle_cycles(input logic [1:0] vsel);
    logic [TW-1:0] c;
    c = TW'(SETTLE_1V8_CYC);
    unique case (vsel)
      CSC_V_3V: c = TW'(SETTLE_3V_CYC);
      CSC_V_5V: c = TW'(SETTLE_5V_CYC);
      default: c = TW'(SETTLE_1V8_CYC);
    endcase
    return c;
  endfunction : settle_cycles

  csc_avalon_slave u_slave (
    .mclk(mclk),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_waitrequest(),
    .req(req)
  );

  csc_timer #(
    .WIDTH(TW)
  ) u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );

  assign wr_ccs = req.wr && (req.addr == CSC_CCS_ADDR);
  assign wr_cif = req.wr && (req.addr == CSC_CIF_ADDR);
  assign pres_lost = !card_presence_input && (state_reg != CSC_ST_OFF)
    && (state_reg != CSC_ST_DEACT);

  // Software control bits
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      converter_on_reg <= CSC_CCS_RESET[CSC_ON_BIT];
      card_voltage_select_reg <= CSC_VSEL_RESET;
      card_supply_request_reg <= 1'b0;
    end else begin
      if (pres_lost) begin
        converter_on_reg <= 1'b0;
      end else if (wr_ccs) begin
        converter_on_reg <= req.wdata[CSC_ON_BIT];
      end
      if (wr_cif) begin
        card_voltage_select_reg <= req.wdata[CSC_VSEL_LSB +: 2];
      end
      // Request refused while locked out or without presence
      if (pres_lost || state_reg == CSC_ST_DEACT) begin
        card_supply_request_reg <= 1'b0;
      end else if (wr_cif) begin
        card_supply_request_reg <= req.wdata[CSC_REQ_BIT]
          && !lockout_reg && card_presence_input;
      end
    end
  end

  // Lockout after a presence-loss power-off
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lockout_reg <= 1'b0;
    end else if (pres_lost) begin
      lockout_reg <= 1'b1;
    end else if (card_presence_input) begin
      lockout_reg <= 1'b0;
    end
  end

  // Sticky record of an automatic abort; set wins over clear-on-write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      abort_seen_reg <= 1'b0;
    end else if (pres_lost) begin
      abort_seen_reg <= 1'b1;
    end else if (wr_cif && req.wdata[CSC_ABORT_BIT]) begin
      abort_seen_reg <= 1'b0;
    end
  end

  // Converter sequence
  always_comb begin
    state_next = state_reg;
    tmr_load = 1'b0;
    tmr_count = TW'(START_CYC);
    unique case (state_reg)
      CSC_ST_OFF: begin
        if (converter_on_reg && card_presence_input) begin
          state_next = CSC_ST_START;
          tmr_load = 1'b1;
        end
      end
      CSC_ST_START: begin
        if (!converter_on_reg) begin
          state_next = CSC_ST_DEACT;
          tmr_load = 1'b1;
          tmr_count = TW'(OFF_CYC);
        end else if (tmr_done) begin
          state_next = CSC_ST_READY;
        end
      end
      CSC_ST_READY: begin
        if (!converter_on_reg) begin
          state_next = CSC_ST_DEACT;
          tmr_load = 1'b1;
          tmr_count = TW'(OFF_CYC);
        end else if (card_supply_request_reg) begin
          state_next = CSC_ST_RAMP;
          tmr_load = 1'b1;
          tmr_count = settle_cycles(card_voltage_select_reg);
        end
      end
      CSC_ST_RAMP, CSC_ST_LOADED: begin
        if (!converter_on_reg) begin
          state_next = CSC_ST_DEACT;
          tmr_load = 1'b1;
          tmr_count = TW'(OFF_CYC);
        end else if (!card_supply_request_reg) begin
          state_next = CSC_ST_READY;
        end else if (card_voltage_select_reg != applied_level_reg) begin
          // Level change restarts the settle wait
          state_next = CSC_ST_RAMP;
          tmr_load = 1'b1;
          tmr_count = settle_cycles(card_voltage_select_reg);
        end else if (state_reg == CSC_ST_RAMP && tmr_done) begin
          state_next = CSC_ST_LOADED;
        end
      end
      CSC_ST_DEACT: begin
        if (tmr_done) begin
          state_next = CSC_ST_OFF;
        end
      end
      default: state_next = CSC_ST_OFF;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= CSC_ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      applied_level_reg <= CSC_V_OFF;
    end else if (tmr_load && state_next == CSC_ST_RAMP) begin
      applied_level_reg <= card_voltage_select_reg;
    end
  end

  // Analog drive, registered so outputs come straight from flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drive_reg <= '0;
    end else begin
      drive_reg.enable <= (state_next != CSC_ST_OFF) && (state_next != CSC_ST_DEACT);
      // Take the new code in the same edge the supply switch closes, so no cycle shows level 0
      drive_reg.level <= (tmr_load && state_next == CSC_ST_RAMP)
        ? card_voltage_select_reg : applied_level_reg;
      // Presence gates the supply directly, not only through the sequencer
      drive_reg.supply <= card_presence_input && !pres_lost
        && (state_next == CSC_ST_RAMP || state_next == CSC_ST_LOADED);
    end
  end

  assign converter_enable = drive_reg.enable;
  assign converter_level = drive_reg.level;
  assign card_supply_output = drive_reg.supply;

  // Read path and waitrequest; RDY and LOAD come only from state, writes cannot touch them
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= !((avs_read || avs_write) && wait_reg);
      if ((avs_read || avs_write) && wait_reg) begin
        rdata_reg <= '0;
        if (avs_address == CSC_CCS_ADDR) begin
          rdata_reg[CSC_ON_BIT] <= converter_on_reg;
          rdata_reg[CSC_RDY_BIT] <= (state_reg == CSC_ST_READY)
            || (state_reg == CSC_ST_RAMP) || (state_reg == CSC_ST_LOADED);
          rdata_reg[CSC_LOAD_BIT] <= (state_reg == CSC_ST_LOADED);
        end else if (avs_address == CSC_CIF_ADDR) begin
          rdata_reg[CSC_VSEL_LSB +: 2] <= card_voltage_select_reg;
          rdata_reg[CSC_REQ_BIT] <= card_supply_request_reg;
          rdata_reg[CSC_PRES_BIT] <= card_presence_input;
          rdata_reg[CSC_ABORT_BIT] <= abort_seen_reg;
        end
      end
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;

endmodule : csc_card_supply_ctrl

//--- verif/csc_properties.sv
`timescale 1ns/1ps
module csc_properties
  import csc_pkg::*;
#(
  parameter int OFF_CYC = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register bus
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Card side
  input wire logic card_presence_input,
  input wire logic converter_enable,
  input wire logic [1:0] converter_level,
  input wire logic card_supply_output
);
  localparam int OFF_MAX = OFF_CYC + 4;
  logic take;
  logic ccs;
  assign take = !avs_waitrequest && (avs_read || avs_write);
  assign ccs = avs_address == CSC_CCS_ADDR;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_wait_answer: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_start_conv: assert property (take && avs_write && ccs && avs_writedata[CSC_ON_BIT] && card_presence_input |-> ##[1:3] converter_enable)
    else $error("converter not started");
  a_stop_conv: assert property (take && avs_write && ccs && !avs_writedata[CSC_ON_BIT] |-> ##[1:3] !card_supply_output)
    else $error("supply kept after converter off");
  a_presence_gate: assert property (!card_presence_input |=> !card_supply_output)
    else $error("supply without card presence");
  a_supply_on_conv: assert property (card_supply_output |-> converter_enable)
    else $error("supply while converter off");
  a_auto_off: assert property ($fell(card_presence_input) && converter_enable |-> ##[1:OFF_MAX] !converter_enable)
    else $error("no automatic power-off");
  a_unused_zero: assert property (take && avs_read && ccs |-> avs_readdata[31:8] == 24'h0 && avs_readdata[4:0] == 5'h0)
    else $error("unused bits not zero");
  a_level_set: assert property (card_supply_output |-> converter_level != CSC_V_OFF)
    else $error("supply without a voltage level");
  a_ready_off: assert property (take && avs_read && ccs && avs_readdata[CSC_RDY_BIT] |-> converter_enable)
    else $error("ready while converter off");
  cover property (take && avs_write && ccs);
  cover property ($rose(card_supply_output));
  cover property ($fell(card_presence_input) && converter_enable);
endmodule : csc_properties

//--- verif/csc_stage_model.sv
`timescale 1ns/1ps
module csc_stage_model (
  // Clock
  input wire logic mclk,
  // Controls from the block
  input wire logic converter_enable,
  input wire logic [1:0] converter_level,
  input wire logic card_supply_output,
  // Socket and rail
  input wire logic card_in,
  output logic card_presence_input,
  output logic [1:0] rail
);
  // Presence changes just after an edge, as a synchronised contact would
  always @(posedge mclk) card_presence_input <= card_in;
  // Rail is dead unless both the stage and the supply switch are on
  always @(posedge mclk) rail <= (converter_enable && card_supply_output) ? converter_level : 2'h0;
endmodule : csc_stage_model

//--- verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import csc_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic card_in = 1'b1;
  logic card_presence_input;
  logic converter_enable;
  logic [1:0] converter_level;
  logic card_supply_output;
  logic [1:0] rail;
  logic [31:0] q;
  logic [31:0] v;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  always #2.5 mclk = ~mclk;
  csc_card_supply_ctrl #(.START_CYC(8), .SETTLE_1V8_CYC(10), .SETTLE_3V_CYC(12),
    .SETTLE_5V_CYC(14), .OFF_CYC(8)) csc_card_supply_ctrl_i (.mclk(mclk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .card_presence_input(card_presence_input),
    .converter_enable(converter_enable), .converter_level(converter_level),
    .card_supply_output(card_supply_output));
  csc_stage_model csc_stage_model_i (.mclk(mclk), .converter_enable(converter_enable),
    .converter_level(converter_level), .card_supply_output(card_supply_output),
    .card_in(card_in), .card_presence_input(card_presence_input), .rail(rail));
  task print_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Request is held until waitrequest is sampled low; data taken at that edge
  task bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    if (n >= 64) begin
      n_mismatch++;
      $display("BAD t=%0t no answer on the register bus", $time);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task poll(input logic [7:0] exp);
    int n;
    n = 0;
    do begin
      bus(1'b0, CSC_CCS_ADDR, 32'h0);
      n++;
    end while (q[7:0] !== exp && n < 40);
    check(q, {24'h0, exp});
  endtask : poll
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    bus(1'b0, CSC_CCS_ADDR, 32'h0);
    check(q, 32'h0);
    bus(1'b1, CSC_CCS_ADDR, 32'h60);
    bus(1'b0, CSC_CCS_ADDR, 32'h0);
    check(q, 32'h0);
    bus(1'b0, 10'h004, 32'h0);
    check(q, 32'h0);
    bus(1'b1, CSC_CCS_ADDR, 32'h80);
    bus(1'b0, CSC_CCS_ADDR, 32'h0);
    check(q, 32'h80);
    poll(8'hC0);
    bus(1'b1, CSC_CCS_ADDR, 32'hE0);
    bus(1'b0, CSC_CCS_ADDR, 32'h0);
    check(q, 32'hC0);
    for (v = 1; v < 4; v++) begin
      bus(1'b1, CSC_CIF_ADDR, 32'h4 | v);
      bus(1'b0, CSC_CCS_ADDR, 32'h0);
      check(q, 32'hC0);
      poll(8'hE0);
      check(32'(converter_level), v);
      check(32'(rail), v);
      bus(1'b1, CSC_CIF_ADDR, v);
      poll(8'hC0);
    end
    bus(1'b1, CSC_CIF_ADDR, 32'h6);
    poll(8'hE0);
    card_in <= 1'b0;
    poll(8'h00);
    check(32'(card_supply_output), 32'h0);
    check(32'(converter_enable), 32'h0);
    bus(1'b1, CSC_CIF_ADDR, 32'h6);
    bus(1'b0, CSC_CIF_ADDR, 32'h0);
    check(q & 32'h4, 32'h0);
    check(32'(rail), 32'h0);
    // Let the deactivation run out before the next start
    repeat (12) @(posedge mclk);
    card_in <= 1'b1;
    bus(1'b1, CSC_CCS_ADDR, 32'h80);
    poll(8'hC0);
    bus(1'b1, CSC_CCS_ADDR, 32'h0);
    poll(8'h00);
    check(32'(converter_enable), 32'h0);
    print_verdict();
  end
endmodule : testbench
bind csc_card_supply_ctrl csc_properties csc_properties_i (.mclk(mclk),
  .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .card_presence_input(card_presence_input),
  .converter_enable(converter_enable), .converter_level(converter_level),
  .card_supply_output(card_supply_output));
